// ==== shared/irq_flag_pkg.sv ====
// Purpose: Shared constants, register map and helpers of the flag bank
// Assumes: 16-bit registers in the low half of a 32-bit Avalon word
// Notes:   Register indices are word addresses; byte address is four times
// ============================================================
// Package
package irq_flag_pkg;

  localparam int NUM_FLAG_REGS = 6;
  localparam int REG_W = 16;

  // Register indices (word addresses)
  localparam logic [3:0] IDX_FLAGS0 = 4'h0;
  localparam logic [3:0] IDX_ENABLE0 = 4'h6;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'hc;
  localparam logic [3:0] IDX_IRQ_MASK = 4'hd;
  localparam logic [3:0] IDX_PENDING = 4'he;

  // Implemented bit positions of each flag register
  localparam logic [15:0] FLAG_IMPL [NUM_FLAG_REGS] = '{
    16'h0007, 16'hfa1f, 16'h0023, 16'h4006, 16'h210e, 16'h0001
  };

  // Values after reset
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;

  // Layout of the controller status and mask registers
  localparam int EV_UNMAPPED_BIT = 6;
  localparam logic [15:0] IRQ_IMPL = 16'h007f;

  // Bus handshake states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  // Merge a write into a 16-bit register by byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0] be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : merge16

endpackage : irq_flag_pkg

// ==== shared/reg_access_if.sv ====
// Purpose: Carries decoded register accesses from the bus port to the core
// Assumes: One access in flight at a time
// Notes:   rdata is combinational from the core
// ============================================================
// Interface
interface reg_access_if;
  logic [3:0] index;
  logic [15:0] wdata;
  logic [1:0] be;
  logic commit_wr;
  logic commit_any;
  logic [15:0] rdata;

  modport bus (output index, output wdata, output be, output commit_wr,
               output commit_any, input rdata);
  modport core (input index, input wdata, input be, input commit_wr,
                input commit_any, output rdata);
endinterface : reg_access_if

// ==== src/flag_word.sv ====
// Purpose: One 16-bit register, either sticky flags or plain read/write bits
// Assumes: set comes from logic on the same clock
// Notes:   Unimplemented positions are held at zero
// ============================================================
// Register word
module flag_word #(
  parameter logic [15:0] IMPL = 16'hffff,
  parameter bit STICKY = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Hardware set and software write
  input wire logic [15:0] set,
  input wire logic wr,
  input wire logic [15:0] wdata,
  input wire logic [1:0] be,
  // Current value
  output logic [15:0] q
);
  import irq_flag_pkg::*;

  logic [15:0] word_q;
  logic [15:0] word_d;

  // Next value: software write first, then hardware set on top
  always_comb begin
    word_d = wr ? merge16(word_q, wdata, be) : word_q; // R3 R14
    if (STICKY) begin
      word_d = word_d | set; // R1 R13
    end
    word_d = word_d & IMPL; // R4
  end

  // Register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      word_q <= FLAG_RESET; // R2
    end else begin
      word_q <= word_d;
    end
  end

  assign q = word_q;
endmodule : flag_word

// ==== src/avalon_port.sv ====
// Purpose: Avalon-MM slave with one wait cycle per access
// Assumes: Master holds the request until it sees waitrequest low
// Notes:   Writes take effect at the edge where waitrequest is seen low
// ============================================================
// Bus port
module avalon_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core side
  reg_access_if.bus acc
);
  import irq_flag_pkg::*;

  bus_state_t state_q;
  bus_state_t state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic wait_q;
  logic wait_d;

  // Decoded request passes straight to the core
  assign acc.index = avs_address;
  assign acc.wdata = avs_writedata[15:0];
  assign acc.be = avs_byteenable[1:0];
  assign acc.commit_any = (state_q == BUS_ACK) && (avs_read || avs_write);
  assign acc.commit_wr = (state_q == BUS_ACK) && avs_write;

  // Handshake: idle with wait high, one acknowledge cycle with wait low
  always_comb begin
    state_d = state_q;
    rdata_d = rdata_q;
    wait_d = wait_q;
    unique case (state_q)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          state_d = BUS_ACK;
          wait_d = 1'b0;
          rdata_d = avs_read ? {16'h0000, acc.rdata} : 32'h0000_0000;
        end
      end
      BUS_ACK: begin
        state_d = BUS_IDLE;
        wait_d = 1'b1;
      end
      default: begin
        state_d = BUS_IDLE;
        wait_d = 1'b1;
      end
    endcase
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= BUS_IDLE;
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b1;
    end else begin
      state_q <= state_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
endmodule : avalon_port

// ==== src/interrupt_flag_status_bank.sv ====
// Purpose: Bank of six interrupt flag registers with enables and a summary
// Assumes: Request inputs are one-cycle or level pulses on the mclk domain
// Notes:   Flags are sticky; software writes zero to clear, one to raise
// ============================================================
// How it works
// R1: Source request sets its flag bit
// R2: All flags clear after reset
// R3: Software reads and writes every flag
// R4: Unimplemented bits read zero, ignore writes
// R5: Register 0 bits 2..0: compare1, capture1, ext0
// R6: Register 1 high byte: serial2, ext2, timers, compare3
// R7: Register 1 bits 4..0: ext1, change, comparator, i2c1
// R8: Register 2: capture3, spi2 event and fault
// R9: Register 3: calendar, i2c2 master and slave
// R10: Register 4: charge time, voltage, checksum, serial errors
// R11: Register 5 bit 0: low-power wake
// R12: Enabled flags alone forward request to processor
// R13: Flag holds until cleared; set beats clear
// R14: Writing one raises the flag in software
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
module interrupt_flag_status_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sources of register 0
  input wire logic compare1_req,
  input wire logic capture1_req,
  input wire logic ext_irq0_req,
  // Sources of register 1
  input wire logic serial2_tx_req,
  input wire logic serial2_rx_req,
  input wire logic ext_irq2_req,
  input wire logic timer5_req,
  input wire logic timer4_req,
  input wire logic compare3_req,
  input wire logic ext_irq1_req,
  input wire logic change_notify_req,
  input wire logic comparator_req,
  input wire logic i2c1_master_req,
  input wire logic i2c1_slave_req,
  // Sources of register 2
  input wire logic capture3_req,
  input wire logic spi2_event_req,
  input wire logic spi2_fault_req,
  // Sources of register 3
  input wire logic calendar_req,
  input wire logic i2c2_master_req,
  input wire logic i2c2_slave_req,
  // Sources of register 4
  input wire logic charge_time_req,
  input wire logic voltage_detect_req,
  input wire logic checksum_done_req,
  input wire logic serial2_error_req,
  input wire logic serial1_error_req,
  // Sources of register 5
  input wire logic low_power_wake_req,
  // Processor request and controller interrupt
  output logic cpu_request,
  output logic irq
);
  import irq_flag_pkg::*;

  // ============================================================
  // Declarations
  reg_access_if acc ();

  logic [15:0] set_vec [NUM_FLAG_REGS];
  logic [15:0] flags [NUM_FLAG_REGS];
  logic [15:0] enables [NUM_FLAG_REGS];
  logic [NUM_FLAG_REGS-1:0] flag_wr;
  logic [NUM_FLAG_REGS-1:0] enable_wr;
  logic [NUM_FLAG_REGS-1:0] new_req;
  logic [NUM_FLAG_REGS-1:0] pending;
  logic unmapped_ev;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic cpu_req_q;
  logic cpu_req_d;
  logic irq_q;
  logic irq_d;
  logic [15:0] rdata;

  // ============================================================
  // Source mapping
  // Register 0: only the low three positions belong to this bank
  assign set_vec[0] = {13'h0000, compare1_req, capture1_req, ext_irq0_req}; // R5

  // Register 1: serial2, external 2, timers 5 and 4, compare 3
  // and the low group of external 1, change notify, comparator, i2c1
  assign set_vec[1] = {serial2_tx_req, serial2_rx_req, ext_irq2_req, timer5_req, // R6
                       timer4_req, 1'b0, compare3_req, 4'h0, // R6
                       ext_irq1_req, change_notify_req, comparator_req, // R7
                       i2c1_master_req, i2c1_slave_req}; // R7

  // Register 2: capture 3 and the two spi2 events
  assign set_vec[2] = {10'h000, capture3_req, 3'h0, spi2_event_req, spi2_fault_req}; // R8

  // Register 3: calendar near the top, i2c2 near the bottom
  assign set_vec[3] = {1'b0, calendar_req, 11'h000, i2c2_master_req, // R9
                       i2c2_slave_req, 1'b0}; // R9

  // Register 4: charge time, voltage detect, checksum, serial errors
  assign set_vec[4] = {2'h0, charge_time_req, 4'h0, voltage_detect_req, 4'h0, // R10
                       checksum_done_req, serial2_error_req, serial1_error_req, // R10
                       1'b0}; // R10

  // Register 5: one wake-up flag
  assign set_vec[5] = {15'h0000, low_power_wake_req}; // R11

  // ============================================================
  // Flag and enable words
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAG_REGS; gi++) begin : g_bank
      // Write strobes decoded from the word index
      assign flag_wr[gi] = acc.commit_wr && (acc.index == IDX_FLAGS0 + 4'(gi)); // R3
      assign enable_wr[gi] = acc.commit_wr && (acc.index == IDX_ENABLE0 + 4'(gi));

      // Sticky flags, set by sources and by software writes of one
      flag_word #(
        .IMPL(FLAG_IMPL[gi]),
        .STICKY(1'b1)
      ) u_flags (
        .mclk(mclk),
        .rst_b(rst_b),
        .set(set_vec[gi]),
        .wr(flag_wr[gi]),
        .wdata(acc.wdata),
        .be(acc.be),
        .q(flags[gi])
      );

      // Enables share the flag layout, plain read/write
      flag_word #(
        .IMPL(FLAG_IMPL[gi]),
        .STICKY(1'b0)
      ) u_enables (
        .mclk(mclk),
        .rst_b(rst_b),
        .set(16'h0000),
        .wr(enable_wr[gi]),
        .wdata(acc.wdata),
        .be(acc.be),
        .q(enables[gi])
      );

      // A source request landing on a clear flag is a new event
      assign new_req[gi] = |(set_vec[gi] & ~flags[gi] & FLAG_IMPL[gi]);
      // Enabled flags reach the processor
      assign pending[gi] = |(flags[gi] & enables[gi]); // R12
    end
  endgenerate

  // ============================================================
  // Bus port
  avalon_port u_bus (
    .mclk(mclk),
    .rst_b(rst_b),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_address(avs_address),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .acc(acc.bus)
  );

  // Any access beyond the last register is reported as an event
  assign unmapped_ev = acc.commit_any && (acc.index > IDX_PENDING);

  // ============================================================
  // Read multiplexer
  // Unused positions and unmapped indices read as zero
  always_comb begin
    rdata = 16'h0000;
    if (acc.index < IDX_ENABLE0) begin
      rdata = flags[acc.index[2:0]]; // R3 R4
    end else if (acc.index < IDX_IRQ_STATUS) begin
      rdata = enables[3'(acc.index - IDX_ENABLE0)];
    end else if (acc.index == IDX_IRQ_STATUS) begin
      rdata = status_q;
    end else if (acc.index == IDX_IRQ_MASK) begin
      rdata = mask_q;
    end else if (acc.index == IDX_PENDING) begin
      rdata = {10'h000, pending};
    end
  end
  assign acc.rdata = rdata;

  // ============================================================
  // Controller status, mask and outputs
  // Status bits are write-one-to-clear; a new event in the same cycle wins
  always_comb begin
    status_d = status_q;
    mask_d = mask_q;
    if (acc.commit_wr && (acc.index == IDX_IRQ_STATUS)) begin
      status_d = status_q & ~merge16(16'h0000, acc.wdata, acc.be);
    end
    if (acc.commit_wr && (acc.index == IDX_IRQ_MASK)) begin
      mask_d = merge16(mask_q, acc.wdata, acc.be) & IRQ_IMPL;
    end
    status_d[NUM_FLAG_REGS-1:0] = status_d[NUM_FLAG_REGS-1:0] | new_req;
    status_d[EV_UNMAPPED_BIT] = status_d[EV_UNMAPPED_BIT] | unmapped_ev;
    status_d = status_d & IRQ_IMPL;
    // Outputs follow their sources one cycle later
    cpu_req_d = |pending; // R12
    irq_d = |(status_q & mask_q);
  end

  // Registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= IRQ_STATUS_RESET;
      mask_q <= IRQ_MASK_RESET;
      cpu_req_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      cpu_req_q <= cpu_req_d;
      irq_q <= irq_d;
    end
  end

  assign cpu_request = cpu_req_q;
  assign irq = irq_q;
endmodule : interrupt_flag_status_bank

// ==== dv/flag_bank_sva.sv ====
// Purpose: Port-level checker for the interrupt flag bank
// Assumes: Bus master holds each request until waitrequest is seen low
// Notes:   Bound to the top module; watches its ports only
// ============================================================
// Checker
module flag_bank_sva
  import irq_flag_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Processor request and controller interrupt
  input wire logic cpu_request,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] rst_cnt_q, rst_cnt_d;
  logic en_seen_q, en_seen_d, mask_seen_q, mask_seen_d, last_ok_q, last_ok_d;
  logic [3:0] last_a_q, last_a_d;
  logic [15:0] last_d_q, last_d_d;
  logic done_rd, done_wr;

  // Completed accesses
  assign done_rd = avs_read && !avs_waitrequest;
  assign done_wr = avs_write && !avs_waitrequest;

  // Cycles since reset, enable and mask history, last read seen
  always_comb begin
    rst_cnt_d = (rst_cnt_q == 2'h2) ? rst_cnt_q : rst_cnt_q + 2'h1;
    en_seen_d = en_seen_q | (done_wr && avs_address >= 4'h6 && avs_address <= 4'hb &&
                             avs_writedata[15:0] != 16'h0000);
    mask_seen_d = mask_seen_q | (done_wr && avs_address == 4'hd &&
                                 avs_writedata[15:0] != 16'h0000);
    last_ok_d = done_rd | (last_ok_q & !done_wr);
    last_a_d = done_rd ? avs_address : last_a_q;
    last_d_d = done_rd ? avs_readdata[15:0] : last_d_q;
  end

  // Helper registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {rst_cnt_q, en_seen_q, mask_seen_q, last_ok_q} <= '0;
      last_a_q <= 4'h0;
      last_d_q <= 16'h0000;
    end else begin
      {rst_cnt_q, en_seen_q, mask_seen_q, last_ok_q} <=
        {rst_cnt_d, en_seen_d, mask_seen_d, last_ok_d};
      last_a_q <= last_a_d;
      last_d_q <= last_d_d;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_wait_taken: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  a_unimpl_zero: assert property (done_rd && avs_address < 4'h6 |->
    (avs_readdata[15:0] & ~FLAG_IMPL[avs_address]) == 16'h0000)
    else $error("unimplemented flag bit reads one");
  a_upper_zero: assert property (done_rd |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_unmapped_zero: assert property (done_rd && avs_address == 4'hf |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_quiet: assert property (rst_cnt_q < 2'h2 |-> !cpu_request && !irq)
    else $error("outputs active right after reset");
  a_cpu_gated: assert property (!en_seen_q |-> !cpu_request)
    else $error("processor request with no enable set");
  a_irq_gated: assert property (!mask_seen_q |-> !irq)
    else $error("interrupt with no mask bit set");
  a_flag_sticky: assert property (done_rd && last_ok_q && avs_address == last_a_q |->
    (avs_readdata[15:0] & last_d_q) == last_d_q)
    else $error("set bit lost without a write");

  c_enable_write: cover property (done_wr && avs_address == 4'h6);
  c_cpu_rise: cover property ($rose(cpu_request));
  c_irq_rise: cover property ($rose(irq));
  c_unmapped: cover property (done_rd && avs_address == 4'hf);
endmodule : flag_bank_sva

bind interrupt_flag_status_bank flag_bank_sva flag_bank_sva_inst (
  .mclk(mclk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_address(avs_address), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cpu_request(cpu_request), .irq(irq));

// ==== dv/flag_source_model.sv ====
// Purpose: Model of the peripheral request sources feeding the bank
// Assumes: Bench commands arrive just after a rising edge
// Notes:   A fire command gives a one-cycle pulse; hold gives a level
// ============================================================
// Source model
module flag_source_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Commands from the bench
  input wire logic fire_stb,
  input wire logic [4:0] fire_idx,
  input wire logic [25:0] hold,
  // Request lines toward the bank
  output logic [25:0] req
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [25:0] pulse_q, pulse_d;

  // Next pulse pattern
  always_comb begin
    pulse_d = '0;
    if (fire_stb) begin
      pulse_d[fire_idx] = 1'b1;
    end
  end

  // Pulse register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  assign req = pulse_q | hold;
endmodule : flag_source_model

// ==== dv/interrupt_flag_status_bank_tb.sv ====
// Purpose: Self-checking bench for the interrupt flag bank
// Assumes: One wait cycle per bus access, registered outputs
// Notes:   Source k sits at register SRC_MAP[k][6:4], bit SRC_MAP[k][3:0]
// ============================================================
// Bench
module interrupt_flag_status_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import irq_flag_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, rd_v;
  logic avs_waitrequest, cpu_request, irq, fire_stb = 1'b0;
  logic [4:0] fire_idx = 5'h0;
  logic [25:0] hold = 26'h0;
  logic [25:0] req;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  localparam logic [7:0] SRC_MAP [26] = '{8'h02, 8'h01, 8'h00, 8'h1f, 8'h1e, 8'h1d, 8'h1c,
    8'h1b, 8'h19, 8'h14, 8'h13, 8'h12, 8'h11, 8'h10, 8'h25, 8'h21, 8'h20, 8'h3e, 8'h32,
    8'h31, 8'h4d, 8'h48, 8'h43, 8'h42, 8'h41, 8'h50};

  interrupt_flag_status_bank interrupt_flag_status_bank_inst (.mclk(mclk), .rst_b(rst_b),
    .avs_read(avs_read), .avs_write(avs_write), .avs_address(avs_address),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .compare1_req(req[0]), .capture1_req(req[1]), .ext_irq0_req(req[2]),
    .serial2_tx_req(req[3]), .serial2_rx_req(req[4]), .ext_irq2_req(req[5]),
    .timer5_req(req[6]), .timer4_req(req[7]), .compare3_req(req[8]), .ext_irq1_req(req[9]),
    .change_notify_req(req[10]), .comparator_req(req[11]), .i2c1_master_req(req[12]),
    .i2c1_slave_req(req[13]), .capture3_req(req[14]), .spi2_event_req(req[15]),
    .spi2_fault_req(req[16]), .calendar_req(req[17]), .i2c2_master_req(req[18]),
    .i2c2_slave_req(req[19]), .charge_time_req(req[20]), .voltage_detect_req(req[21]),
    .checksum_done_req(req[22]), .serial2_error_req(req[23]), .serial1_error_req(req[24]),
    .low_power_wake_req(req[25]), .cpu_request(cpu_request), .irq(irq));

  flag_source_model flag_source_model_inst (.mclk(mclk), .rst_b(rst_b), .fire_stb(fire_stb),
    .fire_idx(fire_idx), .hold(hold), .req(req));

  // Clock
  always #4 mclk = ~mclk;

  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One Avalon access; returns at the edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd_v = avs_readdata;
    if (n == 50) err_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [3:0] be);
    bus(1'b1, a, d, be);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 16'h0000, 4'hf);
    check(rd_v, exp);
  endtask : rd_chk

  task automatic fire(input int k);
    fire_idx <= k[4:0];
    fire_stb <= 1'b1;
    @(posedge mclk);
    fire_stb <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask : fire

  task automatic end_sim();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a++) rd_chk(a[3:0], 32'h0);
    $display("test reset done");
    for (int a = 0; a < 12; a++) begin
      wr(a[3:0], 16'hffff, 4'hf);
      rd_chk(a[3:0], {16'h0000, FLAG_IMPL[a % 6]});
      wr(a[3:0], 16'h0000, 4'hf);
      rd_chk(a[3:0], 32'h0);
    end
    wr(4'h1, 16'hffff, 4'h1);
    rd_chk(4'h1, 32'h0000001f);
    wr(4'h1, 16'h0000, 4'hf);
    $display("test write done");
    for (int k = 0; k < 26; k++) begin
      fire(k);
      rd_chk({1'b0, SRC_MAP[k][6:4]}, 32'h1 << SRC_MAP[k][3:0]);
      wr({1'b0, SRC_MAP[k][6:4]}, 16'h0000, 4'hf);
    end
    rd_chk(4'hc, 32'h0000007f);
    wr(4'hc, 16'h007f, 4'hf);
    rd_chk(4'hc, 32'h0);
    $display("test sources done");
    hold[6] <= 1'b1;
    wr(4'h1, 16'h0000, 4'hf);
    hold[6] <= 1'b0;
    rd_chk(4'h1, 32'h00001000);
    wr(4'h6, 16'h0001, 4'hf);
    fire(2);
    check({31'h0, cpu_request}, 32'h1);
    rd_chk(4'he, 32'h1);
    wr(4'h6, 16'h0000, 4'hf);
    repeat (2) @(posedge mclk);
    check({31'h0, cpu_request}, 32'h0);
    $display("test enable done");
    wr(4'h0, 16'h0000, 4'hf);
    wr(4'hc, 16'h007f, 4'hf);
    wr(4'hd, 16'h0001, 4'hf);
    fire(2);
    check({31'h0, irq}, 32'h1);
    wr(4'hd, 16'h0040, 4'hf);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    rd_chk(4'hf, 32'h0);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    wr(4'hc, 16'h0041, 4'hf);
    rd_chk(4'hc, 32'h0);
    check({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    end_sim();
  end
endmodule : interrupt_flag_status_bank_tb
